/* File: hw/i2c_status_mask.sv */
// Two-wire bus status flags, address masking and byte engine
//
// The implementer's own choices: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
module i2c_status_mask
  import i2c_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_s req,
  output logic [15:0] rdata,
  output logic irq,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  state_s st_ff;
  state_s nxt_st;

  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic master_mode;
  logic ten_bit;
  logic tx_write;

  // Compare under a mask: a set mask bit ignores that position
  function automatic logic masked_eq(input logic [7:0] a, input logic [7:0] b, input logic [7:0] m);
    masked_eq = ((a ^ b) & ~m) == 8'h00;
  endfunction

  // Edges and bus conditions from the synchronised lines
  assign scl_rise = st_ff.scl_s2 & ~st_ff.scl_d;
  assign scl_fall = ~st_ff.scl_s2 & st_ff.scl_d;
  assign start_det = st_ff.scl_s2 & st_ff.scl_d & st_ff.sda_d & ~st_ff.sda_s2;
  assign stop_det = st_ff.scl_s2 & st_ff.scl_d & ~st_ff.sda_d & st_ff.sda_s2;
  assign master_mode = st_ff.ctrl[CTL_MASTER];
  assign ten_bit = st_ff.ctrl[CTL_TEN_BIT];
  assign tx_write = req.wr && req.addr == OFS_TRANSMIT;

  // Next-state logic for the whole block
  always_comb begin
    logic [7:0] byte_in;
    logic [INT_W-1:0] ev;
    logic [INT_W-1:0] clr;
    logic [15:0] status_word;
    logic [2:0] bit_sel;
    byte_in = st_ff.sshift;
    ev = '0;
    clr = '0;
    bit_sel = 3'(BITS_PER_BYTE - 4'h1 - st_ff.scnt);
    status_word = '0;
    nxt_st = st_ff;

    // Two-stage synchronisers and edge history
    nxt_st.scl_s1 = scl_in;
    nxt_st.scl_s2 = st_ff.scl_s1;
    nxt_st.sda_s1 = sda_in;
    nxt_st.sda_s2 = st_ff.sda_s1;
    nxt_st.scl_d = st_ff.scl_s2;
    nxt_st.sda_d = st_ff.sda_s2;

    // Status word as software sees it
    status_word[BIT_ACK_RESULT] = st_ff.ack_result;
    status_word[BIT_TX_BUSY] = st_ff.tx_busy;
    status_word[BIT_ACK_WINDOW] = st_ff.ack_window;
    status_word[BIT_COLLISION] = st_ff.collision;
    status_word[BIT_GENERAL_CALL] = st_ff.gcall;
    status_word[BIT_TEN_MATCH] = st_ff.ten_match;
    status_word[BIT_WRITE_COLL] = st_ff.wcol;
    status_word[BIT_OVERFLOW] = st_ff.ovf;
    status_word[BIT_DATA] = st_ff.data_flag;
    status_word[BIT_STOP] = st_ff.stop_seen;
    status_word[BIT_START] = st_ff.start_seen;
    status_word[BIT_READ] = st_ff.dir_read;
    status_word[BIT_RX_FULL] = st_ff.rx_full;
    status_word[BIT_TX_FULL] = st_ff.tx_full;

    // Read data stand only in the cycle after the strobe
    nxt_st.rdata = '0;
    if (req.rd) begin
      case (req.addr)
        OFS_STATUS: nxt_st.rdata = status_word;
        OFS_MASK: nxt_st.rdata = 16'(st_ff.mask);
        OFS_CONTROL: nxt_st.rdata = 16'(st_ff.ctrl);
        OFS_OWN_ADDR: nxt_st.rdata = 16'(st_ff.own);
        OFS_TRANSMIT: nxt_st.rdata = 16'(st_ff.tx_data);
        OFS_RECEIVE: begin
          nxt_st.rdata = 16'(st_ff.rx_data);
          nxt_st.rx_full = 1'b0;
        end
        OFS_INT_STATUS: nxt_st.rdata = 16'(st_ff.int_status);
        OFS_INT_MASK: nxt_st.rdata = 16'(st_ff.int_mask);
        default: nxt_st.rdata = '0;
      endcase
    end

    // Software writes; clears come first so hardware sets below win
    if (req.wr) begin
      case (req.addr)
        OFS_STATUS: begin
          // Only sticky flags take a zero; hardware-driven bits ignore writes
          if (!req.wdata[BIT_COLLISION]) nxt_st.collision = 1'b0;
          if (!req.wdata[BIT_OVERFLOW]) nxt_st.ovf = 1'b0;
          if (!req.wdata[BIT_START]) nxt_st.start_seen = 1'b0;
          if (!req.wdata[BIT_STOP]) nxt_st.stop_seen = 1'b0;
          if (!req.wdata[BIT_WRITE_COLL]) nxt_st.wcol = 1'b0;
        end
        OFS_MASK: nxt_st.mask = req.wdata[MASK_W-1:0];
        OFS_CONTROL: nxt_st.ctrl = req.wdata[CTL_W-1:0];
        OFS_OWN_ADDR: nxt_st.own = req.wdata[MASK_W-1:0];
        OFS_INT_STATUS: clr = req.wdata[INT_W-1:0];
        OFS_INT_MASK: nxt_st.int_mask = req.wdata[INT_W-1:0];
        default: ;
      endcase
    end

    // Transmit register write: refused while the master engine has a byte on the wire
    if (tx_write) begin
      if (st_ff.tx_busy) begin
        nxt_st.wcol = 1'b1;
      end else begin
        nxt_st.tx_data = req.wdata[7:0];
        nxt_st.tx_full = 1'b1;
      end
    end

    // Master byte engine: drives the clock, shifts out, samples ack
    case (st_ff.mphase)
      M_IDLE: begin
        if (tx_write && !st_ff.tx_busy && master_mode) begin
          nxt_st.mphase = M_LOW;
          nxt_st.tx_busy = 1'b1;
          nxt_st.mshift = req.wdata[7:0];
          nxt_st.mcnt = '0;
          nxt_st.mdiv = '0;
          nxt_st.scl_oe = 1'b1;
        end
      end
      M_LOW: begin
        // Data moves one cycle after the clock falls, never with the rise
        if (st_ff.mdiv == '0) begin
          // Release data in the ack slot so the slave can answer
          nxt_st.sda_oe = (st_ff.mcnt == BITS_PER_BYTE) ? 1'b0 : ~st_ff.mshift[7];
        end
        if (st_ff.mdiv == HALF_LAST) begin
          nxt_st.mdiv = '0;
          nxt_st.scl_oe = 1'b0;
          nxt_st.mphase = M_HIGH;
        end else begin
          nxt_st.mdiv = st_ff.mdiv + 4'h1;
        end
      end
      M_HIGH: begin
        if (st_ff.mdiv == HALF_LAST) begin
          nxt_st.mdiv = '0;
          if (st_ff.mcnt == BITS_PER_BYTE) begin
            nxt_st.ack_result = st_ff.sda_s2;
            nxt_st.tx_busy = 1'b0;
            nxt_st.tx_full = 1'b0;
            nxt_st.mphase = M_IDLE;
            ev[IRQ_TX_DONE] = 1'b1;
          end else if (!st_ff.sda_oe && !st_ff.sda_s2) begin
            // Another master pulled data low while we released it
            nxt_st.collision = 1'b1;
            nxt_st.tx_busy = 1'b0;
            nxt_st.sda_oe = 1'b0;
            nxt_st.mphase = M_IDLE;
            ev[IRQ_COLL] = 1'b1;
          end else begin
            nxt_st.mshift = {st_ff.mshift[6:0], 1'b0};
            nxt_st.mcnt = st_ff.mcnt + 4'h1;
            nxt_st.scl_oe = 1'b1;
            nxt_st.mphase = M_LOW;
          end
        end else begin
          nxt_st.mdiv = st_ff.mdiv + 4'h1;
        end
      end
      default: begin
        nxt_st.mphase = M_IDLE;
        nxt_st.tx_busy = 1'b0;
        nxt_st.scl_oe = 1'b0;
        nxt_st.sda_oe = 1'b0;
      end
    endcase

    // Slave side: follows the external clock when not master
    if (!master_mode) begin
      if (scl_rise && st_ff.sphase != S_IDLE) begin
        if (st_ff.scnt < BITS_PER_BYTE) begin
          nxt_st.sshift = {st_ff.sshift[6:0], st_ff.sda_s2};
        end else begin
          nxt_st.ack_window = 1'b0;
        end
        nxt_st.scnt = st_ff.scnt + 4'h1;
      end

      if (scl_fall && st_ff.sphase != S_IDLE) begin
        if (st_ff.scnt == BITS_PER_BYTE) begin
          nxt_st.ack_window = 1'b1;
          nxt_st.sda_oe = 1'b0;
          case (st_ff.sphase)
            S_ADDR: begin
              if (byte_in == GENERAL_CALL_ADDR && st_ff.ctrl[CTL_GCALL_EN]) begin
                nxt_st.gcall = 1'b1;
                nxt_st.data_flag = 1'b0;
                nxt_st.dir_read = 1'b0;
                nxt_st.sda_oe = 1'b1;
                nxt_st.sphase = S_DATA;
              end else if (ten_bit) begin
                if (byte_in[7:3] == TEN_BIT_PREFIX &&
                    masked_eq({6'h00, byte_in[2:1]}, {6'h00, st_ff.own[9:8]},
                              {6'h00, st_ff.mask[9:8]})) begin
                  nxt_st.sda_oe = 1'b1;
                  if (byte_in[0] && st_ff.ten_match) begin
                    // Repeated start with read after a full ten-bit match
                    nxt_st.dir_read = 1'b1;
                    nxt_st.data_flag = 1'b0;
                    nxt_st.sphase = S_DATA;
                  end else begin
                    nxt_st.sphase = S_ADDR2;
                  end
                end else begin
                  nxt_st.sphase = S_SKIP;
                end
              end else if (masked_eq({byte_in[7:1], 1'b0}, {st_ff.own[6:0], 1'b0},
                                     {st_ff.mask[6:0], 1'b0})) begin
                nxt_st.sda_oe = 1'b1;
                nxt_st.data_flag = 1'b0;
                nxt_st.dir_read = byte_in[0];
                nxt_st.sphase = S_DATA;
              end else begin
                nxt_st.sphase = S_SKIP;
              end
            end
            S_ADDR2: begin
              if (masked_eq(byte_in, st_ff.own[7:0], st_ff.mask[7:0])) begin
                nxt_st.ten_match = 1'b1;
                nxt_st.data_flag = 1'b0;
                nxt_st.dir_read = 1'b0;
                nxt_st.sda_oe = 1'b1;
                nxt_st.sphase = S_DATA;
              end else begin
                nxt_st.sphase = S_SKIP;
              end
            end
            S_DATA: begin
              if (!st_ff.dir_read) begin
                nxt_st.data_flag = 1'b1;
                ev[IRQ_RX] = 1'b1;
                if (st_ff.rx_full && nxt_st.rx_full) begin
                  // Holding register unread: keep it and refuse the byte
                  nxt_st.ovf = 1'b1;
                end else begin
                  nxt_st.rx_data = byte_in;
                  nxt_st.rx_full = 1'b1;
                  nxt_st.sda_oe = 1'b1;
                end
              end else begin
                // Eighth bit of a read byte is out: the byte is sent
                nxt_st.tx_full = 1'b0;
              end
            end
            default: ;
          endcase
        end else if (st_ff.scnt == ACK_SLOT) begin
          nxt_st.scnt = '0;
          nxt_st.sda_oe = (st_ff.sphase == S_DATA && st_ff.dir_read) ? ~st_ff.tx_data[7] : 1'b0;
        end else if (st_ff.sphase == S_DATA && st_ff.dir_read) begin
          nxt_st.sda_oe = ~st_ff.tx_data[bit_sel];
        end
      end
    end

    // Start and Stop detection; the last one seen is recorded
    if (start_det) begin
      nxt_st.start_seen = 1'b1;
      nxt_st.stop_seen = 1'b0;
      nxt_st.sphase = S_ADDR;
      nxt_st.scnt = '0;
      nxt_st.ack_window = 1'b0;
      ev[IRQ_START] = 1'b1;
    end else if (stop_det) begin
      nxt_st.stop_seen = 1'b1;
      nxt_st.start_seen = 1'b0;
      nxt_st.gcall = 1'b0;
      nxt_st.ten_match = 1'b0;
      nxt_st.sphase = S_IDLE;
      nxt_st.scnt = '0;
      nxt_st.ack_window = 1'b0;
      if (!master_mode) nxt_st.sda_oe = 1'b0;
      ev[IRQ_STOP] = 1'b1;
    end

    // Sticky interrupt status, write one to clear, set wins
    nxt_st.int_status = (st_ff.int_status & ~clr) | ev;
    nxt_st.irq = |(nxt_st.int_status & nxt_st.int_mask);
    nxt_st.line_level = 1'b0;
  end

  // State register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_ff <= '{sphase: S_IDLE, mphase: M_IDLE, scl_s1: 1'b1, scl_s2: 1'b1, sda_s1: 1'b1,
                 sda_s2: 1'b1, scl_d: 1'b1, sda_d: 1'b1, default: '0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // Outputs straight from the state register
  assign rdata = st_ff.rdata;
  assign irq = st_ff.irq;
  assign scl_out = st_ff.line_level;
  assign scl_oe = st_ff.scl_oe;
  assign sda_out = st_ff.line_level;
  assign sda_oe = st_ff.sda_oe;

endmodule

/* File: common/i2c_status_pkg.sv */
// Constants, types and state layout for the two-wire status and address mask block
// Overview of operation
// - Master ack slot end records NACK as 1, ACK as 0
// - Transmit busy flag spans eight bits plus ack
// - Slave ack window: 8th falling to 9th rising
// - Master bus collision sets sticky flag until cleared
// - General call match sets flag, Stop clears it
// - Ten-bit second byte match sets flag, Stop clears
// - Transmit write while busy rejected, write collision set
// - Byte arriving into full holding register sets overflow
// - Address match clears data flag, received data byte sets it
// - Start and Stop flags record last bus condition
// - Slave direction flag: one read, zero write
// - Receive full set on store, cleared by read
// - Transmit full set on write, cleared on completion
// - Ten-bit mode: mask bit makes address bit don't-care
// - Seven-bit mode: mask bit x covers byte bit x+1
// - Address width select picks ten or seven bits
package i2c_status_pkg;

  // Timing of the master serial clock
  localparam int CLK_PERIOD_NS = 8;
  localparam int MASTER_HALF_NS = 80;
  localparam int MASTER_HALF_CYC = (MASTER_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] HALF_LAST = 4'(MASTER_HALF_CYC - 1);

  // Register offsets (byte addresses)
  localparam logic [4:0] OFS_STATUS = 5'h00;
  localparam logic [4:0] OFS_MASK = 5'h04;
  localparam logic [4:0] OFS_CONTROL = 5'h08;
  localparam logic [4:0] OFS_OWN_ADDR = 5'h0c;
  localparam logic [4:0] OFS_TRANSMIT = 5'h10;
  localparam logic [4:0] OFS_RECEIVE = 5'h14;
  localparam logic [4:0] OFS_INT_STATUS = 5'h18;
  localparam logic [4:0] OFS_INT_MASK = 5'h1c;

  // Status register bit positions
  localparam int BIT_ACK_RESULT = 15;
  localparam int BIT_TX_BUSY = 14;
  localparam int BIT_ACK_WINDOW = 13;
  localparam int BIT_COLLISION = 10;
  localparam int BIT_GENERAL_CALL = 9;
  localparam int BIT_TEN_MATCH = 8;
  localparam int BIT_WRITE_COLL = 7;
  localparam int BIT_OVERFLOW = 6;
  localparam int BIT_DATA = 5;
  localparam int BIT_STOP = 4;
  localparam int BIT_START = 3;
  localparam int BIT_READ = 2;
  localparam int BIT_RX_FULL = 1;
  localparam int BIT_TX_FULL = 0;

  // Control register bit positions
  localparam int CTL_TEN_BIT = 0;
  localparam int CTL_GCALL_EN = 1;
  localparam int CTL_MASTER = 2;
  localparam int CTL_W = 3;

  // Interrupt status bit positions
  localparam int IRQ_RX = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_COLL = 2;
  localparam int IRQ_START = 3;
  localparam int IRQ_STOP = 4;
  localparam int INT_W = 5;

  // Field widths and bus codes
  localparam int MASK_W = 10;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] ACK_SLOT = 4'h9;
  localparam logic [7:0] GENERAL_CALL_ADDR = 8'h00;
  localparam logic [4:0] TEN_BIT_PREFIX = 5'h1e;

  typedef enum logic [2:0] {
    M_IDLE = 3'b001,
    M_LOW = 3'b010,
    M_HIGH = 3'b100
  } master_e;

  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_ADDR = 5'b00010,
    S_ADDR2 = 5'b00100,
    S_DATA = 5'b01000,
    S_SKIP = 5'b10000
  } slave_e;

  // Register port request
  typedef struct packed {
    logic [4:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  // Whole state of the block
  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic sda_s1;
    logic sda_s2;
    logic scl_d;
    logic sda_d;
    slave_e sphase;
    logic [3:0] scnt;
    logic [7:0] sshift;
    master_e mphase;
    logic [3:0] mcnt;
    logic [3:0] mdiv;
    logic [7:0] mshift;
    logic ack_result;
    logic tx_busy;
    logic ack_window;
    logic collision;
    logic gcall;
    logic ten_match;
    logic wcol;
    logic ovf;
    logic data_flag;
    logic stop_seen;
    logic start_seen;
    logic dir_read;
    logic rx_full;
    logic tx_full;
    logic [MASK_W-1:0] mask;
    logic [CTL_W-1:0] ctrl;
    logic [MASK_W-1:0] own;
    logic [7:0] tx_data;
    logic [7:0] rx_data;
    logic [INT_W-1:0] int_status;
    logic [INT_W-1:0] int_mask;
    logic [15:0] rdata;
    logic irq;
    logic scl_oe;
    logic sda_oe;
    logic line_level;
  } state_s;

endpackage

/* File: test/i2c_status_mask_properties.sv */
// Concurrent checks on the status and address mask block ports
`timescale 1ns/10ps
module i2c_status_mask_properties
  import i2c_status_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire reg_req_s req,
  input wire logic [15:0] rdata,
  input wire logic irq,
  input wire logic scl_in,
  input wire logic scl_oe,
  input wire logic sda_oe
);
  logic master_ff;
  logic imz_ff;
  logic [5:0] low_ff;
  logic [5:0] high_ff;
  logic tx_go;

  // Mirror of mode and interrupt mask, run lengths of the clock pull
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      master_ff <= 1'b0;
      imz_ff <= 1'b1;
      low_ff <= 6'h0;
      high_ff <= 6'h0;
    end else begin
      if (req.wr && req.addr == OFS_CONTROL) begin
        master_ff <= req.wdata[CTL_MASTER];
      end
      if (req.wr && req.addr == OFS_INT_MASK) begin
        imz_ff <= req.wdata[INT_W-1:0] == '0;
      end
      low_ff <= scl_oe ? 6'h0 : low_ff + 6'(low_ff != 6'h3f);
      high_ff <= !scl_oe ? 6'h0 : high_ff + 6'(high_ff != 6'h3f);
    end
  end

  // Transmit write that an idle master has to accept
  assign tx_go = req.wr && req.addr == OFS_TRANSMIT && master_ff && low_ff > 6'h1e;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  property p_rdata_quiet;
    !$past(req.rd) |-> rdata == 16'h0;
  endproperty
  a_rdata_quiet: assert property (p_rdata_quiet)
    else $error("read data not zero outside a read answer");
  property p_mask_width;
    $past(req.rd) && $past(req.addr) == OFS_MASK |-> rdata[15:MASK_W] == '0;
  endproperty
  a_mask_width: assert property (p_mask_width)
    else $error("mask register upper bits not zero");
  property p_start_stop;
    $past(req.rd) && $past(req.addr) == OFS_STATUS |-> !(rdata[BIT_START] && rdata[BIT_STOP]);
  endproperty
  a_start_stop: assert property (p_start_stop)
    else $error("start and stop flags both set");
  property p_irq_masked;
    imz_ff && $past(imz_ff) |-> !irq;
  endproperty
  a_irq_masked: assert property (p_irq_masked)
    else $error("interrupt raised with all sources masked");
  property p_slave_clock;
    !master_ff && !$past(master_ff) |-> !scl_oe;
  endproperty
  a_slave_clock: assert property (p_slave_clock)
    else $error("clock pulled low in slave mode");
  property p_tx_begin;
    tx_go |=> scl_oe [*8];
  endproperty
  a_tx_begin: assert property (p_tx_begin)
    else $error("master byte did not start after transmit write");
  property p_half_len;
    $fell(scl_oe) |-> high_ff == 6'h0a;
  endproperty
  a_half_len: assert property (p_half_len)
    else $error("master clock low half not ten cycles");
  property p_data_on_low;
    !master_ff && $changed(sda_oe) |-> !$past(scl_in, 2);
  endproperty
  a_data_on_low: assert property (p_data_on_low)
    else $error("slave data changed while clock high");
endmodule

bind i2c_status_mask i2c_status_mask_properties i_props (
  .clk(clk),
  .rst(rst),
  .req(req),
  .rdata(rdata),
  .irq(irq),
  .scl_in(scl_in),
  .scl_oe(scl_oe),
  .sda_oe(sda_oe)
);

/* File: test/i2c_bus_peer.sv */
// Behavioural far-side bus device: frames toward the slave logic, answers to the master logic
`timescale 1ns/10ps
module i2c_bus_peer (
  input wire logic scl,
  input wire logic sda,
  output logic scl_low,
  output logic sda_low
);
  logic driving;
  logic nack_mode;
  logic [8:0] got;
  int falls;

  // Lines released, clock stands still
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
    driving = 1'b0;
    nack_mode = 1'b0;
    falls = 0;
  end

  // Prepare for one master byte: answer choice and optional data jam
  task automatic arm(input logic nack, input logic jam);
    nack_mode = nack;
    falls = 0;
    sda_low = jam;
  endtask

  // Start or repeated start: data falls while clock is high
  task automatic start();
    // Step off the block's clock edge so both lines move between samples
    #2;
    driving = 1'b1;
    sda_low = 1'b0;
    #80 scl_low = 1'b0;
    #80 sda_low = 1'b1;
    #80 scl_low = 1'b1;
  endtask

  // Stop: data rises while clock is high, then the clock stands still
  task automatic stop();
    sda_low = 1'b1;
    #80 scl_low = 1'b0;
    #80 sda_low = 1'b0;
    #80 driving = 1'b0;
  endtask

  // Nine clock periods of 160 ns, top bit first; the last is the acknowledge
  task automatic xfer(input logic [8:0] out, output logic [8:0] in);
    for (int i = 8; i >= 0; i--) begin
      #20 sda_low = !out[i];
      #60 scl_low = 1'b0;
      #80 in[i] = sda;
      scl_low = 1'b1;
    end
  endtask

  // Acknowledge slot toward the master logic, held past the ninth rise
  always @(negedge scl) begin
    if (!driving) begin
      falls = falls + 1;
      if (falls == 9) begin
        sda_low = !nack_mode; // Answer
        @(posedge scl);
        #100 sda_low = 1'b0;
      end
    end
  end

  // Capture of master bits on each rise
  always @(posedge scl) begin
    if (!driving) begin
      got = {got[7:0], sda};
    end
  end
endmodule

/* File: test/i2c_status_mask_bench.sv */
// Self-checking bench for the two-wire status and address mask block
`timescale 1ns/10ps
module i2c_status_mask_bench;
  import i2c_status_pkg::*;
  logic clk;
  logic rst;
  reg_req_s req;
  logic [15:0] rdata;
  logic irq;
  logic scl_out;
  logic scl_oe;
  logic sda_out;
  logic sda_oe;
  logic peer_scl_low;
  logic peer_sda_low;
  logic scl_line;
  logic sda_line;
  logic [8:0] got;
  int err_count;
  int num_checks;

  // Open-drain lines with pull-ups
  assign scl_line = (scl_oe ? scl_out : 1'b1) & !peer_scl_low;
  assign sda_line = (sda_oe ? sda_out : 1'b1) & !peer_sda_low;

  // Clock at 125 MHz
  initial begin
    clk = 1'b0;
    forever #4 clk = !clk;
  end

  i2c_status_mask i_dut (
    .clk(clk),
    .rst(rst),
    .req(req),
    .rdata(rdata),
    .irq(irq),
    .scl_in(scl_line),
    .scl_out(scl_out),
    .scl_oe(scl_oe),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe(sda_oe)
  );

  i2c_bus_peer i_peer (
    .scl(scl_line),
    .sda(sda_line),
    .scl_low(peer_scl_low),
    .sda_low(peer_sda_low)
  );

  function automatic logic [15:0] b(input int n);
    return 16'h1 << n;
  endfunction

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  // Read, mask and compare
  task automatic cr(input logic [4:0] a, input logic [15:0] m, input logic [15:0] e);
    logic [15:0] v;
    @(posedge clk);
    req <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 v = rdata;
    chk(v & m, e);
  endtask

  // One byte from the peer, acknowledge bit compared
  task automatic ack(input logic [7:0] by, input logic e);
    i_peer.xfer({by, 1'b1}, got);
    chk({15'h0, got[0]}, {15'h0, e});
  endtask

  task automatic report_and_stop();
    $display("Checks: %0d, mismatches: %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    err_count = 0;
    num_checks = 0;
    req = '0;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cr(OFS_STATUS, 16'hffff, 16'h0); // Cleared
    wr(OFS_STATUS, 16'hffff);
    cr(OFS_STATUS, 16'hffff, 16'h0); // Writes ignored
    wr(OFS_MASK, 16'hffff);
    cr(OFS_MASK, 16'hffff, 16'h03ff); // Ten bits
    cr(5'h1e, 16'hffff, 16'h0); // Unmapped
    // Seven-bit slave write with overflow
    wr(OFS_OWN_ADDR, 16'h002a);
    wr(OFS_MASK, 16'h0001);
    i_peer.start();
    ack(8'h56, 1'b0); // Masked match
    cr(OFS_STATUS, 16'hffff, b(BIT_START)); // Address, write
    fork
      ack(8'h5c, 1'b0); // Data taken
      begin
        repeat (8) @(negedge scl_line);
        repeat (5) @(posedge clk);
        cr(OFS_STATUS, b(BIT_ACK_WINDOW), b(BIT_ACK_WINDOW)); // Ack slot open
      end
    join
    cr(OFS_STATUS, 16'hffff, b(BIT_START) | b(BIT_DATA) | b(BIT_RX_FULL)); // Stored
    ack(8'h33, 1'b1); // Dropped
    cr(OFS_STATUS, b(BIT_OVERFLOW), b(BIT_OVERFLOW)); // Overflow
    cr(OFS_RECEIVE, 16'hffff, 16'h005c); // First byte
    i_peer.stop();
    cr(OFS_STATUS, 16'hffff, b(BIT_STOP) | b(BIT_DATA) | b(BIT_OVERFLOW)); // Stop last
    wr(OFS_STATUS, ~b(BIT_OVERFLOW));
    cr(OFS_STATUS, 16'hffff, b(BIT_STOP) | b(BIT_DATA)); // Zero clears
    // Interrupt masked, unmasked, cleared
    chk({15'h0, irq}, 16'h0); // Masked
    cr(OFS_INT_STATUS, 16'hffff, 16'h0019); // Events
    wr(OFS_INT_MASK, 16'h0001);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h1); // Raised
    wr(OFS_INT_STATUS, 16'h001f);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0); // Cleared
    wr(OFS_INT_MASK, 16'h0);
    // Unmasked mismatch
    wr(OFS_MASK, 16'h0);
    i_peer.start();
    ack(8'h56, 1'b1); // Exact bit needed
    i_peer.stop();
    // General call
    wr(OFS_CONTROL, b(CTL_GCALL_EN));
    i_peer.start();
    ack(8'h00, 1'b0); // Accepted
    cr(OFS_STATUS, b(BIT_GENERAL_CALL), b(BIT_GENERAL_CALL)); // Set
    i_peer.stop();
    cr(OFS_STATUS, b(BIT_GENERAL_CALL), 16'h0); // Stop clears
    // Slave read of the transmit register
    wr(OFS_TRANSMIT, 16'h00a5);
    cr(OFS_STATUS, b(BIT_TX_FULL), b(BIT_TX_FULL)); // Full
    i_peer.start();
    ack(8'h55, 1'b0); // Read address
    cr(OFS_STATUS, b(BIT_READ) | b(BIT_DATA) | b(BIT_TX_FULL), b(BIT_READ) | b(BIT_TX_FULL)); // Read flag
    i_peer.xfer(9'h1ff, got);
    chk({8'h0, got[8:1]}, 16'h00a5); // Byte out
    cr(OFS_STATUS, b(BIT_TX_FULL), 16'h0); // Done
    i_peer.stop();
    // Ten-bit address with one masked bit
    wr(OFS_CONTROL, b(CTL_TEN_BIT));
    wr(OFS_OWN_ADDR, 16'h02c5);
    wr(OFS_MASK, 16'h0004);
    i_peer.start();
    ack(8'hf4, 1'b0); // Ten-bit header
    ack(8'hc1, 1'b0); // Masked low byte
    cr(OFS_STATUS, b(BIT_TEN_MATCH), b(BIT_TEN_MATCH)); // Matched
    i_peer.start();
    ack(8'hf5, 1'b0); // Read after full match
    cr(OFS_STATUS, b(BIT_READ) | b(BIT_TEN_MATCH), b(BIT_READ) | b(BIT_TEN_MATCH)); // Read set, match kept
    i_peer.stop();
    cr(OFS_STATUS, b(BIT_TEN_MATCH), 16'h0); // Stop clears
    // Master bytes: acknowledge, write collision, refusal
    wr(OFS_CONTROL, b(CTL_MASTER));
    i_peer.arm(1'b0, 1'b0);
    wr(OFS_TRANSMIT, 16'h0096);
    cr(OFS_STATUS, b(BIT_TX_BUSY) | b(BIT_TX_FULL), b(BIT_TX_BUSY) | b(BIT_TX_FULL)); // Busy
    wr(OFS_TRANSMIT, 16'h0011);
    cr(OFS_STATUS, b(BIT_WRITE_COLL), b(BIT_WRITE_COLL)); // Rejected
    repeat (200) @(posedge clk);
    cr(OFS_STATUS, b(BIT_ACK_RESULT) | b(BIT_TX_BUSY) | b(BIT_TX_FULL), 16'h0); // Ack seen
    chk({7'h0, i_peer.got}, {7'h0, 8'h96, 1'b0}); // Top bit first
    cr(OFS_INT_STATUS, b(IRQ_TX_DONE), b(IRQ_TX_DONE)); // Byte done
    wr(OFS_STATUS, ~b(BIT_WRITE_COLL));
    cr(OFS_STATUS, b(BIT_WRITE_COLL), 16'h0); // Zero clears
    i_peer.arm(1'b1, 1'b0);
    wr(OFS_TRANSMIT, 16'h0069);
    repeat (200) @(posedge clk);
    cr(OFS_STATUS, b(BIT_ACK_RESULT) | b(BIT_TX_BUSY), b(BIT_ACK_RESULT)); // Refused
    // Master collision on a jammed data line
    i_peer.arm(1'b0, 1'b1);
    wr(OFS_TRANSMIT, 16'h00ff);
    repeat (200) @(posedge clk);
    cr(OFS_STATUS, b(BIT_COLLISION), b(BIT_COLLISION)); // Detected
    i_peer.arm(1'b0, 1'b0);
    cr(OFS_INT_STATUS, b(IRQ_COLL), b(IRQ_COLL)); // Event
    wr(OFS_STATUS, ~b(BIT_COLLISION));
    cr(OFS_STATUS, b(BIT_COLLISION), 16'h0); // Zero clears
    report_and_stop();
  end

  // Watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
endmodule
